/* inc/eict_pkg.sv */
package eict_pkg;
   // =============================================
   // operand classes and modes
   typedef enum logic [2:0] {
      CLS_ROT_MULTI = 3'h0,
      CLS_PUSH_MULTI = 3'h1,
      CLS_POP_MULTI = 3'h2,
      CLS_LONG_CALL = 3'h3,
      CLS_EXT_ROT = 3'h4,
      CLS_EXT_PUSH = 3'h5,
      CLS_EXT_POP = 3'h6,
      CLS_DOUBLE = 3'h7
   } eict_class_t;
   typedef enum logic [2:0] {
      AM_REG = 3'h0,
      AM_IND = 3'h1,
      AM_AINC = 3'h2,
      AM_IMM = 3'h3,
      AM_IDX = 3'h4,
      AM_SYM = 3'h5,
      AM_ABS = 3'h6
   } eict_mode_t;
   typedef enum logic [1:0] {
      DST_REG = 2'h0,
      DST_PC = 2'h1,
      DST_MEM = 2'h2
   } eict_dst_t;
   typedef enum logic [2:0] {
      OP_TRANSFER = 3'h0,
      OP_TEST = 3'h1,
      OP_COMPARE = 3'h2,
      OP_SUM = 3'h3,
      OP_DIFF = 3'h4,
      OP_OTHER = 3'h5
   } eict_op_t;
   // =============================================
   // widths, reset values and adjustments
   localparam int CYC_W = 6;
   localparam int WRD_W = 3;
   localparam int CNT_W = 5;
   localparam logic [5:0] CYC_RST = 6'h00;
   localparam logic [2:0] WRD_RST = 3'h0;
   localparam logic [5:0] ROT_BASE = 6'h01;
   localparam logic [5:0] MULTI_BASE = 6'h02;
   localparam logic [5:0] REPEAT_BASE = 6'h01;
   localparam logic [5:0] SP_PENALTY = 6'h01;
   localparam logic [5:0] NOWB_BW = 6'h01;
   localparam logic [5:0] NOWB_A = 6'h02;
   localparam logic [5:0] PC_SHORT = 6'h01;
   localparam logic [2:0] MULTI_WORDS = 3'h1;
   localparam logic [4:0] ROT_MAX = 5'h04;
   localparam logic [4:0] MULTI_MAX = 5'h10;
   localparam logic [2:0] ROW_CALL = 3'h0;
   localparam logic [2:0] ROW_ROT_BW = 3'h1;
   localparam logic [2:0] ROW_ROT_A = 3'h2;
   localparam logic [2:0] ROW_PUSH_BW = 3'h3;
   localparam logic [2:0] ROW_PUSH_A = 3'h4;
   localparam logic [2:0] ROW_POP_BW = 3'h5;
   localparam logic [2:0] ROW_POP_A = 3'h6;
   // =============================================
   // single-operand tables, column = source mode; zero words = unsupported
   localparam logic [5:0] F2_CYC [0:6][0:6] = '{
      '{6'h04, 6'h05, 6'h05, 6'h04, 6'h06, 6'h06, 6'h06},
      '{6'h00, 6'h04, 6'h04, 6'h00, 6'h05, 6'h05, 6'h05},
      '{6'h00, 6'h06, 6'h06, 6'h00, 6'h07, 6'h07, 6'h07},
      '{6'h04, 6'h04, 6'h04, 6'h04, 6'h05, 6'h05, 6'h05},
      '{6'h05, 6'h06, 6'h06, 6'h06, 6'h07, 6'h07, 6'h07},
      '{6'h03, 6'h00, 6'h00, 6'h00, 6'h05, 6'h05, 6'h05},
      '{6'h04, 6'h00, 6'h00, 6'h00, 6'h07, 6'h07, 6'h07}};
   localparam logic [2:0] F2_WRD [0:6][0:6] = '{
      '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2},
      '{3'h2, 3'h2, 3'h2, 3'h0, 3'h3, 3'h3, 3'h3},
      '{3'h2, 3'h2, 3'h2, 3'h0, 3'h3, 3'h3, 3'h3},
      '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3},
      '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3},
      '{3'h2, 3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h3},
      '{3'h2, 3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h3}};
   // =============================================
   // double-operand tables, row = source mode, column = destination kind
   localparam logic [5:0] DBL_BW_CYC [0:6][0:2] = '{
      '{6'h02, 6'h03, 6'h05}, '{6'h03, 6'h03, 6'h06}, '{6'h03, 6'h04, 6'h06},
      '{6'h03, 6'h04, 6'h06}, '{6'h04, 6'h05, 6'h07}, '{6'h04, 6'h05, 6'h07},
      '{6'h04, 6'h05, 6'h07}};
   localparam logic [5:0] DBL_A_CYC [0:6][0:2] = '{
      '{6'h02, 6'h03, 6'h07}, '{6'h04, 6'h04, 6'h09}, '{6'h04, 6'h05, 6'h09},
      '{6'h03, 6'h04, 6'h08}, '{6'h05, 6'h06, 6'h0A}, '{6'h05, 6'h06, 6'h0A},
      '{6'h05, 6'h06, 6'h0A}};
   localparam logic [2:0] DBL_WRD [0:6][0:2] = '{
      '{3'h2, 3'h2, 3'h3}, '{3'h2, 3'h2, 3'h3}, '{3'h2, 3'h2, 3'h3},
      '{3'h3, 3'h3, 3'h4}, '{3'h3, 3'h3, 3'h4}, '{3'h3, 3'h3, 3'h4},
      '{3'h3, 3'h3, 3'h4}};
endpackage

/* inc/eict_seq_if.sv */
`timescale 1ns/1ns
interface eict_seq_if import eict_pkg::*; ();
   logic load;
   logic [CYC_W-1:0] load_cycles;
   logic busy;
   logic done;
   logic [CYC_W-1:0] remaining;
   modport ctrl (output load, output load_cycles, input busy, input done, input remaining);
   modport seq (input load, input load_cycles, output busy, output done, output remaining);
endinterface

/* hdl/eict_seq.sv */
`timescale 1ns/1ns
module eict_seq import eict_pkg::*; (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   eict_seq_if.seq sq
);
   // =============================================
   // execution cycle counter
   wire last_cycle = sq.remaining == 6'h01;

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         sq.remaining <= CYC_RST;
         sq.busy <= 1'b0;
         sq.done <= 1'b0;
      end else if (clk_en_i) begin
         sq.done <= !sq.load && last_cycle;
         if (sq.load) begin
            sq.remaining <= sq.load_cycles;
            sq.busy <= 1'b1;
         end else if (sq.busy) begin
            // RL21
            sq.remaining <= sq.remaining - 6'h01;
            sq.busy <= !last_cycle;
         end
      end
   end

   // =============================================
   // checks
   load_to_busy_a: assert property ( // RL21
      @(posedge core_clk_i) disable iff (!reset_n_i)
      clk_en_i && sq.load
      |=> sq.busy && sq.remaining == $past(sq.load_cycles))
      else $error("load did not start the count");

   count_end_a: assert property ( // RL21
      @(posedge core_clk_i) disable iff (!reset_n_i)
      clk_en_i && sq.busy && last_cycle && !sq.load
      |=> sq.done && !sq.busy && sq.remaining == CYC_RST)
      else $error("count did not end on its last cycle");
endmodule

/* hdl/eict_top.sv */
`timescale 1ns/1ns
// Operation
// RL1: multi-bit register rotates take n cycles, one word
// RL2: word push/pop multiple take 2+n, one word
// RL3: 20-bit push/pop multiple take 2+2n, one word
// RL4: long call timing per source addressing mode
// RL5: stack-pointer indexed base adds one cycle
// RL6: byte/word extended rotate right timing
// RL7: 20-bit extended rotate right timing
// RL8: byte/word extended push timing
// RL9: 20-bit extended push timing
// RL10: extended pop timing into register or memory
// RL11: register source to register or program counter
// RL12: register source to memory destination
// RL13: indirect source timing
// RL14: autoincrement like indirect, program counter slower
// RL15: immediate source timing
// RL16: indexed, symbolic or absolute source timing
// RL17: repeated register-register takes n+1 cycles
// RL18: byte/word no-writeback opcodes one cycle less
// RL19: 20-bit no-writeback opcodes two cycles less
// RL20: transfer/sum/difference to program counter one less
// RL21: cycles counted on the core clock
// RL22: unavailable mode combinations get no timing
module eict_top import eict_pkg::*; (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic start_i,
   input eict_class_t class_i,
   input wire logic wide_i,
   input eict_mode_t src_mode_i,
   input eict_dst_t dst_kind_i,
   input eict_op_t op_i,
   input wire logic [CNT_W-1:0] count_i,
   input wire logic base_sp_i,
   input wire logic repeat_i,
   output logic busy_o,
   output logic done_o,
   output logic unsupported_o,
   output logic [CYC_W-1:0] cycles_o,
   output logic [WRD_W-1:0] words_o,
   output logic [CYC_W-1:0] remaining_o
);
   // =============================================
   // operand decode
   eict_seq_if sq ();

   wire mode_ok = src_mode_i != 3'h7;
   wire dst_ok = dst_kind_i != 2'h3;
   eict_mode_t mode;
   logic [1:0] dst_idx;
   assign mode = eict_mode_t'(mode_ok ? src_mode_i : AM_REG);
   assign dst_idx = dst_ok ? dst_kind_i : DST_REG;

   wire is_reg = mode == AM_REG;
   wire is_idx = mode == AM_IDX;
   wire is_far_src = mode inside {AM_IMM, AM_IDX, AM_SYM, AM_ABS};
   wire cnt_zero = count_i == 5'h00;
   wire dst_is_reg = dst_idx == DST_REG;
   wire dst_is_pc = dst_idx == DST_PC;
   wire dst_is_mem = dst_idx == DST_MEM;

   wire [CYC_W-1:0] n_once = {1'b0, count_i};
   // a 20-bit register moves as two words
   wire [CYC_W-1:0] n_twice = {count_i, 1'b0};

   wire is_rot_multi = class_i == CLS_ROT_MULTI;
   wire is_stack_multi = class_i inside {CLS_PUSH_MULTI, CLS_POP_MULTI};
   wire is_call = class_i == CLS_LONG_CALL;
   wire is_ext_rot = class_i == CLS_EXT_ROT;
   wire is_ext_push = class_i == CLS_EXT_PUSH;
   wire is_double = class_i == CLS_DOUBLE;

   // =============================================
   // register-only multi-bit and multiple-register forms
   wire [CYC_W-1:0] rot_multi_cyc = n_once; // RL1
   wire rot_multi_bad = !is_reg || cnt_zero || count_i > ROT_MAX; // RL22

   wire [CYC_W-1:0] stack_n = wide_i ? n_twice : n_once; // RL3
   wire [CYC_W-1:0] stack_multi_cyc = MULTI_BASE + stack_n; // RL2
   wire stack_multi_bad = !is_reg || cnt_zero || count_i > MULTI_MAX; // RL22

   // =============================================
   // single-operand table forms
   logic [2:0] f2_row;
   assign f2_row = is_call ? ROW_CALL :
                   is_ext_rot ? (wide_i ? ROW_ROT_A : ROW_ROT_BW) :
                   is_ext_push ? (wide_i ? ROW_PUSH_A : ROW_PUSH_BW) :
                   (wide_i ? ROW_POP_A : ROW_POP_BW);

   wire [CYC_W-1:0] f2_tab_cyc = F2_CYC[f2_row][mode]; // RL4
   wire [WRD_W-1:0] f2_tab_wrd = F2_WRD[f2_row][mode]; // RL8

   // stack pointer as index base costs an address cycle
   wire sp_extra = base_sp_i && is_idx && (is_call || is_ext_push); // RL5
   wire [CYC_W-1:0] sp_add = sp_extra ? SP_PENALTY : CYC_RST;

   wire rot_reg = is_ext_rot && is_reg;
   wire [CYC_W-1:0] rot_reg_cyc = ROT_BASE + n_once; // RL6
   wire [CYC_W-1:0] f2_cyc = rot_reg ? rot_reg_cyc : f2_tab_cyc + sp_add; // RL7
   wire f2_bad = !mode_ok || f2_tab_wrd == WRD_RST || (rot_reg && cnt_zero); // RL22

   // =============================================
   // double-operand forms
   wire [CYC_W-1:0] dbl_bw = DBL_BW_CYC[mode][dst_idx]; // RL13
   wire [CYC_W-1:0] dbl_a = DBL_A_CYC[mode][dst_idx]; // RL16
   wire [CYC_W-1:0] dbl_tab_cyc = wide_i ? dbl_a : dbl_bw; // RL11
   wire [WRD_W-1:0] dbl_wrd = DBL_WRD[mode][dst_idx]; // RL12

   // nothing is written back for these opcodes
   wire no_writeback = op_i inside {OP_TRANSFER, OP_TEST, OP_COMPARE};
   wire nowb_cut = dst_is_mem && no_writeback; // RL18
   wire [CYC_W-1:0] nowb_sub = !nowb_cut ? CYC_RST : wide_i ? NOWB_A : NOWB_BW; // RL19

   wire pc_op = op_i inside {OP_TRANSFER, OP_SUM, OP_DIFF};
   wire pc_cut = dst_is_pc && is_far_src && pc_op; // RL20
   wire [CYC_W-1:0] pc_sub = pc_cut ? PC_SHORT : CYC_RST;

   wire repeat_rr = repeat_i && is_reg && dst_is_reg;
   wire [CYC_W-1:0] repeat_cyc = REPEAT_BASE + n_once; // RL17

   wire [CYC_W-1:0] dbl_cyc = repeat_rr ? repeat_cyc : dbl_tab_cyc - nowb_sub - pc_sub; // RL14
   // repeat is only defined for register to register
   wire repeat_bad = repeat_i && (!repeat_rr || cnt_zero);
   wire dbl_bad = !mode_ok || !dst_ok || repeat_bad; // RL22

   // =============================================
   // selection
   logic [CYC_W-1:0] next_cycles;
   logic [WRD_W-1:0] next_words;
   logic next_unsup;

   assign next_cycles = is_rot_multi ? rot_multi_cyc :
                        is_stack_multi ? stack_multi_cyc :
                        is_double ? dbl_cyc :
                        f2_cyc;
   assign next_words = (is_rot_multi || is_stack_multi) ? MULTI_WORDS :
                       is_double ? dbl_wrd :
                       f2_tab_wrd;
   assign next_unsup = is_rot_multi ? rot_multi_bad :
                       is_stack_multi ? stack_multi_bad :
                       is_double ? dbl_bad :
                       f2_bad;

   // a request during a count is refused, not queued
   wire accept = clk_en_i && start_i && !sq.busy;
   wire take = accept && !next_unsup;

   assign sq.load = take;
   assign sq.load_cycles = next_cycles;

   // =============================================
   // result registers
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         cycles_o <= CYC_RST;
         words_o <= WRD_RST;
         unsupported_o <= 1'b0;
      end else if (accept) begin
         // RL22
         cycles_o <= next_unsup ? CYC_RST : next_cycles;
         words_o <= next_unsup ? WRD_RST : next_words;
         unsupported_o <= next_unsup;
      end
   end

   assign busy_o = sq.busy;
   assign done_o = sq.done;
   assign remaining_o = sq.remaining;

   eict_seq u_seq (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .sq(sq)
   );

   // =============================================
   // checks
   rot_multi_time_a: assert property ( // RL1
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_rot_multi
      |=> cycles_o == {1'b0, $past(count_i)} && words_o == 3'h1)
      else $error("multi rotate timing wrong");

   word_multi_time_a: assert property ( // RL2
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_stack_multi && !wide_i
      |=> cycles_o == 6'h02 + {1'b0, $past(count_i)} && words_o == 3'h1)
      else $error("word multi stack timing wrong");

   wide_multi_time_a: assert property ( // RL3
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_stack_multi && wide_i
      |=> cycles_o == 6'h02 + {$past(count_i), 1'b0} && words_o == 3'h1)
      else $error("wide multi stack timing wrong");

   call_time_a: assert property ( // RL4
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_call && mode inside {AM_SYM, AM_ABS}
      |=> cycles_o == 6'h06 && words_o == 3'h2)
      else $error("long call memory timing wrong");

   call_imm_a: assert property ( // RL4
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_call && mode == AM_IMM
      |=> cycles_o == 6'h04 && words_o == 3'h2)
      else $error("long call immediate timing wrong");

   sp_penalty_a: assert property ( // RL5
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && (is_call || is_ext_push) && is_idx
      |=> cycles_o == $past(f2_tab_cyc) + ($past(base_sp_i) ? 6'h01 : 6'h00))
      else $error("stack pointer penalty wrong");

   rot_bw_time_a: assert property ( // RL6
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_ext_rot && !wide_i && mode == AM_IND
      |=> cycles_o == 6'h04 && words_o == 3'h2)
      else $error("byte word rotate timing wrong");

   rot_a_time_a: assert property ( // RL7
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_ext_rot && wide_i && mode == AM_ABS
      |=> cycles_o == 6'h07 && words_o == 3'h3)
      else $error("wide rotate timing wrong");

   push_bw_time_a: assert property ( // RL8
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_ext_push && !wide_i && mode == AM_IMM
      |=> cycles_o == 6'h04 && words_o == 3'h3)
      else $error("byte word push timing wrong");

   push_a_time_a: assert property ( // RL9
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_ext_push && wide_i && is_reg
      |=> cycles_o == 6'h05 && words_o == 3'h2)
      else $error("wide push timing wrong");

   pop_time_a: assert property ( // RL10
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && class_i == CLS_EXT_POP && is_reg
      |=> cycles_o == ($past(wide_i) ? 6'h04 : 6'h03) && words_o == 3'h2)
      else $error("pop timing wrong");

   reg_src_time_a: assert property ( // RL11
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && is_reg && !repeat_i && dst_is_pc
      |=> cycles_o == 6'h03 && words_o == 3'h2)
      else $error("register to program counter timing wrong");

   reg_mem_time_a: assert property ( // RL12
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && is_reg && dst_is_mem && op_i == OP_OTHER
      |=> cycles_o == ($past(wide_i) ? 6'h07 : 6'h05) && words_o == 3'h3)
      else $error("register to memory timing wrong");

   ind_src_time_a: assert property ( // RL13
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && mode == AM_IND && dst_is_reg
      |=> cycles_o == ($past(wide_i) ? 6'h04 : 6'h03) && words_o == 3'h2)
      else $error("indirect source timing wrong");

   ainc_pc_time_a: assert property ( // RL14
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && mode == AM_AINC && dst_is_pc
      |=> cycles_o == ($past(wide_i) ? 6'h05 : 6'h04))
      else $error("autoincrement to program counter wrong");

   imm_mem_time_a: assert property ( // RL15
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && mode == AM_IMM && dst_is_mem && op_i == OP_OTHER
      |=> cycles_o == ($past(wide_i) ? 6'h08 : 6'h06) && words_o == 3'h4)
      else $error("immediate to memory timing wrong");

   far_reg_time_a: assert property ( // RL16
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && mode inside {AM_IDX, AM_SYM, AM_ABS} && dst_is_reg
      |=> cycles_o == ($past(wide_i) ? 6'h05 : 6'h04) && words_o == 3'h3)
      else $error("indexed source timing wrong");

   repeat_time_a: assert property ( // RL17
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && repeat_i
      |=> cycles_o == {1'b0, $past(count_i)} + 6'h01)
      else $error("repeat timing wrong");

   nowb_bw_a: assert property ( // RL18
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && is_reg && dst_is_mem && !wide_i && op_i inside {OP_TRANSFER, OP_TEST, OP_COMPARE}
      |=> cycles_o == 6'h04)
      else $error("byte word no writeback cut wrong");

   nowb_a_a: assert property ( // RL19
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && mode == AM_IND && dst_is_mem && wide_i && op_i inside {OP_TRANSFER, OP_TEST, OP_COMPARE}
      |=> cycles_o == 6'h07)
      else $error("wide no writeback cut wrong");

   pc_cut_a: assert property ( // RL20
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && is_double && mode == AM_IMM && dst_is_pc && op_i == OP_SUM
      |=> cycles_o == 6'h03)
      else $error("program counter cut wrong");

   busy_span_a: assert property ( // RL21
      @(posedge core_clk_i) disable iff (!reset_n_i)
      take && next_cycles == 6'h02 ##1 clk_en_i [*2]
      |-> busy_o && $past(busy_o) ##1 !busy_o && done_o)
      else $error("busy span does not match count");

   unsup_a: assert property ( // RL22
      @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && class_i == CLS_EXT_POP && mode inside {AM_IND, AM_AINC, AM_IMM}
      |=> unsupported_o && !busy_o && cycles_o == 6'h00)
      else $error("unavailable mode given a timing");
endmodule

/* sim/eict_stall_model.sv */
`timescale 1ns/1ns
// =============================================
// core-side stall source: drops one enable in three
module eict_stall_model (
   input wire logic core_clk_i,
   input wire logic stall_on_i,
   output logic clk_en_o
);
   logic [1:0] phase = 2'h0;
   logic stall_q = 1'b0;
   // changes only on the falling edge, so the rising edge always sees a settled enable
   always @(negedge core_clk_i) begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      stall_q <= stall_on_i;
   end
   assign clk_en_o = !(stall_q && phase == 2'h2);
endmodule

/* sim/tb_eict_top.sv */
`timescale 1ns/1ns
module tb_eict_top import eict_pkg::*; ;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic start_i = 1'b0;
   logic wide_i = 1'b0;
   logic base_sp_i = 1'b0;
   logic repeat_i = 1'b0;
   logic stall_on = 1'b0;
   logic clk_en_i;
   eict_class_t class_i = CLS_ROT_MULTI;
   eict_mode_t src_mode_i = AM_REG;
   eict_dst_t dst_kind_i = DST_REG;
   eict_op_t op_i = OP_OTHER;
   logic [CNT_W-1:0] count_i = 5'h01;
   logic busy_o, done_o, unsupported_o;
   logic [CYC_W-1:0] cycles_o, remaining_o;
   logic [WRD_W-1:0] words_o;
   int n_mismatch = 0;
   int compares = 0;
   // =============================================
   // clock, far side and design
   initial forever #2 core_clk_i = ~core_clk_i;
   eict_stall_model eict_stall_model_i (.core_clk_i(core_clk_i), .stall_on_i(stall_on), .clk_en_o(clk_en_i));
   eict_top eict_top_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .start_i(start_i),
      .class_i(class_i), .wide_i(wide_i), .src_mode_i(src_mode_i), .dst_kind_i(dst_kind_i), .op_i(op_i),
      .count_i(count_i), .base_sp_i(base_sp_i), .repeat_i(repeat_i), .busy_o(busy_o), .done_o(done_o),
      .unsupported_o(unsupported_o), .cycles_o(cycles_o), .words_o(words_o), .remaining_o(remaining_o));
   // =============================================
   // shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one request; busy is counted only on enabled edges, a stall must not shorten it
   task automatic go(input eict_class_t c, input logic w, input eict_mode_t m, input eict_dst_t d, input eict_op_t o,
      input logic [CNT_W-1:0] n, input logic sp, input logic rp, input logic [7:0] ec, input logic [7:0] ew);
      int k;
      int t;
      k = 0;
      @(negedge core_clk_i);
      class_i = c; wide_i = w; src_mode_i = m; dst_kind_i = d; op_i = o;
      count_i = n; base_sp_i = sp; repeat_i = rp; start_i = 1'b1;
      do @(posedge core_clk_i); while (clk_en_i !== 1'b1);
      @(negedge core_clk_i);
      start_i = 1'b0;
      check({2'h0, cycles_o}, ec);
      check({5'h00, words_o}, ew);
      check({7'h00, unsupported_o}, {7'h00, ew == 8'h00});
      if (ew != 8'h00) check({2'h0, remaining_o}, ec);
      for (t = 0; t < 80; t++) begin
         @(posedge core_clk_i);
         if (clk_en_i === 1'b1 && busy_o === 1'b1) k++;
         #1;
         if (busy_o !== 1'b1) break;
      end
      check(k[7:0], ec);
      if (ew != 8'h00) check({7'h00, done_o}, 8'h01);
   endtask
   task automatic op1(input eict_class_t c, input logic w, input eict_mode_t m, input logic [CNT_W-1:0] n,
      input logic sp, input logic [7:0] ec, input logic [7:0] ew);
      go(c, w, m, DST_REG, OP_OTHER, n, sp, 1'b0, ec, ew);
   endtask
   task automatic dbl(input logic w, input eict_mode_t m, input eict_dst_t d, input eict_op_t o,
      input logic [7:0] ec, input logic [7:0] ew);
      go(CLS_DOUBLE, w, m, d, o, 5'h01, 1'b0, 1'b0, ec, ew);
   endtask
   // =============================================
   // scenarios
   task automatic t_single();
      op1(CLS_ROT_MULTI, 1'b0, AM_REG, 5'h01, 1'b0, 8'h01, 8'h01);
      op1(CLS_ROT_MULTI, 1'b1, AM_REG, 5'h04, 1'b0, 8'h04, 8'h01);
      op1(CLS_ROT_MULTI, 1'b0, AM_REG, 5'h05, 1'b0, 8'h00, 8'h00);
      op1(CLS_ROT_MULTI, 1'b0, AM_IND, 5'h02, 1'b0, 8'h00, 8'h00);
      op1(CLS_PUSH_MULTI, 1'b0, AM_REG, 5'h03, 1'b0, 8'h05, 8'h01);
      op1(CLS_POP_MULTI, 1'b0, AM_REG, 5'h10, 1'b0, 8'h12, 8'h01);
      op1(CLS_PUSH_MULTI, 1'b1, AM_REG, 5'h02, 1'b0, 8'h06, 8'h01);
      op1(CLS_POP_MULTI, 1'b1, AM_REG, 5'h10, 1'b0, 8'h22, 8'h01);
      op1(CLS_PUSH_MULTI, 1'b0, AM_REG, 5'h11, 1'b0, 8'h00, 8'h00);
      op1(CLS_LONG_CALL, 1'b0, AM_REG, 5'h00, 1'b0, 8'h04, 8'h01);
      op1(CLS_LONG_CALL, 1'b0, AM_AINC, 5'h00, 1'b0, 8'h05, 8'h01);
      op1(CLS_LONG_CALL, 1'b0, AM_IMM, 5'h00, 1'b0, 8'h04, 8'h02);
      op1(CLS_LONG_CALL, 1'b0, AM_SYM, 5'h00, 1'b0, 8'h06, 8'h02);
      op1(CLS_LONG_CALL, 1'b0, AM_IDX, 5'h00, 1'b1, 8'h07, 8'h02);
      op1(CLS_LONG_CALL, 1'b0, AM_ABS, 5'h00, 1'b1, 8'h06, 8'h02);
      $display("t_single finished");
   endtask
   task automatic t_ext();
      stall_on = 1'b1;
      op1(CLS_EXT_ROT, 1'b0, AM_REG, 5'h02, 1'b0, 8'h03, 8'h02);
      op1(CLS_EXT_ROT, 1'b0, AM_IND, 5'h01, 1'b0, 8'h04, 8'h02);
      op1(CLS_EXT_ROT, 1'b0, AM_SYM, 5'h01, 1'b0, 8'h05, 8'h03);
      op1(CLS_EXT_ROT, 1'b0, AM_IMM, 5'h01, 1'b0, 8'h00, 8'h00);
      op1(CLS_EXT_ROT, 1'b1, AM_REG, 5'h01, 1'b0, 8'h02, 8'h02);
      op1(CLS_EXT_ROT, 1'b1, AM_AINC, 5'h01, 1'b0, 8'h06, 8'h02);
      op1(CLS_EXT_ROT, 1'b1, AM_ABS, 5'h01, 1'b0, 8'h07, 8'h03);
      stall_on = 1'b0;
      op1(CLS_EXT_PUSH, 1'b0, AM_IND, 5'h00, 1'b0, 8'h04, 8'h02);
      op1(CLS_EXT_PUSH, 1'b0, AM_IMM, 5'h00, 1'b0, 8'h04, 8'h03);
      op1(CLS_EXT_PUSH, 1'b0, AM_IDX, 5'h00, 1'b1, 8'h06, 8'h03);
      op1(CLS_EXT_PUSH, 1'b1, AM_REG, 5'h00, 1'b0, 8'h05, 8'h02);
      op1(CLS_EXT_PUSH, 1'b1, AM_AINC, 5'h00, 1'b0, 8'h06, 8'h02);
      op1(CLS_EXT_PUSH, 1'b1, AM_IMM, 5'h00, 1'b0, 8'h06, 8'h03);
      op1(CLS_EXT_PUSH, 1'b1, AM_SYM, 5'h00, 1'b0, 8'h07, 8'h03);
      op1(CLS_EXT_POP, 1'b0, AM_REG, 5'h00, 1'b0, 8'h03, 8'h02);
      op1(CLS_EXT_POP, 1'b0, AM_IDX, 5'h00, 1'b0, 8'h05, 8'h03);
      op1(CLS_EXT_POP, 1'b1, AM_REG, 5'h00, 1'b0, 8'h04, 8'h02);
      op1(CLS_EXT_POP, 1'b1, AM_ABS, 5'h00, 1'b0, 8'h07, 8'h03);
      op1(CLS_EXT_POP, 1'b0, AM_IND, 5'h00, 1'b0, 8'h00, 8'h00);
      $display("t_ext finished");
   endtask
   task automatic t_double();
      dbl(1'b0, AM_REG, DST_REG, OP_OTHER, 8'h02, 8'h02);
      dbl(1'b1, AM_REG, DST_PC, OP_OTHER, 8'h03, 8'h02);
      dbl(1'b0, AM_REG, DST_MEM, OP_OTHER, 8'h05, 8'h03);
      dbl(1'b1, AM_REG, DST_MEM, OP_SUM, 8'h07, 8'h03);
      dbl(1'b1, AM_IND, DST_REG, OP_OTHER, 8'h04, 8'h02);
      dbl(1'b0, AM_IND, DST_MEM, OP_OTHER, 8'h06, 8'h03);
      dbl(1'b1, AM_IND, DST_MEM, OP_OTHER, 8'h09, 8'h03);
      dbl(1'b0, AM_AINC, DST_PC, OP_OTHER, 8'h04, 8'h02);
      dbl(1'b1, AM_AINC, DST_PC, OP_OTHER, 8'h05, 8'h02);
      dbl(1'b0, AM_IMM, DST_REG, OP_OTHER, 8'h03, 8'h03);
      dbl(1'b1, AM_IMM, DST_MEM, OP_OTHER, 8'h08, 8'h04);
      dbl(1'b1, AM_SYM, DST_REG, OP_OTHER, 8'h05, 8'h03);
      dbl(1'b0, AM_ABS, DST_PC, OP_OTHER, 8'h05, 8'h03);
      dbl(1'b1, AM_IDX, DST_MEM, OP_OTHER, 8'h0A, 8'h04);
      dbl(1'b0, AM_IDX, DST_MEM, OP_TRANSFER, 8'h06, 8'h04);
      dbl(1'b0, AM_REG, DST_MEM, OP_TEST, 8'h04, 8'h03);
      dbl(1'b1, AM_IND, DST_MEM, OP_COMPARE, 8'h07, 8'h03);
      dbl(1'b1, AM_ABS, DST_MEM, OP_TRANSFER, 8'h08, 8'h04);
      dbl(1'b1, AM_IMM, DST_PC, OP_SUM, 8'h03, 8'h03);
      dbl(1'b0, AM_SYM, DST_PC, OP_DIFF, 8'h04, 8'h03);
      dbl(1'b0, AM_IMM, DST_PC, OP_COMPARE, 8'h04, 8'h03);
      dbl(1'b0, AM_REG, DST_PC, OP_TRANSFER, 8'h03, 8'h02);
      go(CLS_DOUBLE, 1'b0, AM_REG, DST_REG, OP_OTHER, 5'h05, 1'b0, 1'b1, 8'h06, 8'h02);
      go(CLS_DOUBLE, 1'b1, AM_REG, DST_REG, OP_TRANSFER, 5'h1F, 1'b0, 1'b1, 8'h20, 8'h02);
      go(CLS_DOUBLE, 1'b0, AM_REG, DST_MEM, OP_OTHER, 5'h03, 1'b0, 1'b1, 8'h00, 8'h00);
      dbl(1'b0, AM_REG, eict_dst_t'(2'h3), OP_OTHER, 8'h00, 8'h00);
      dbl(1'b0, eict_mode_t'(3'h7), DST_REG, OP_OTHER, 8'h00, 8'h00);
      $display("t_double finished");
   endtask
   // a request while busy must leave the running count untouched
   task automatic t_refuse();
      int t;
      @(negedge core_clk_i);
      class_i = CLS_LONG_CALL; src_mode_i = AM_IDX; base_sp_i = 1'b0; start_i = 1'b1;
      @(negedge core_clk_i);
      class_i = CLS_ROT_MULTI; src_mode_i = AM_REG; count_i = 5'h01;
      @(negedge core_clk_i);
      start_i = 1'b0;
      check({2'h0, cycles_o}, 8'h06);
      check({2'h0, remaining_o}, 8'h05);
      for (t = 0; t < 20; t++) begin
         @(posedge core_clk_i);
         #1;
         if (busy_o !== 1'b1) break;
      end
      check({7'h00, done_o}, 8'h01);
      check({2'h0, cycles_o}, 8'h06);
      $display("t_refuse finished");
   endtask
   // =============================================
   // main sequence and watchdog
   initial begin
      repeat (10) @(posedge core_clk_i);
      @(negedge core_clk_i) reset_n_i = 1'b1;
      check({busy_o, unsupported_o, cycles_o}, 8'h00);
      check({5'h00, words_o}, 8'h00);
      t_single();
      t_ext();
      t_double();
      t_refuse();
      summarize();
   end
   initial begin
      #100000;
      n_mismatch++;
      summarize();
   end
endmodule
